// File: rtl/srp_pkg.sv
// constants shared by both ends of the sdram refresh/power link
// assumes a single 20 mhz clock shared by both ends
package srp_pkg;
  // ****************************************
  // widths and encodings
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int ROW_W = 13;
  localparam int CNT_W = 4;
  localparam int LOW_W = 21;
  localparam int BURST_W = 14;
  localparam int REFI_W = 8;
  // {row_strobe_n, column_strobe_n, write_strobe_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_IDLE = 13'h0000;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PS = 50000;
  localparam int CLK_KHZ = 20000;
  localparam int T_RC_PS = 63000;
  localparam int T_RP_PS = 21000;
  localparam int T_IS_PS = 1500;
  localparam int T_XSR_PS = T_RC_PS + T_IS_PS;
  localparam int T_PDE_PS = T_IS_PS + CLK_PS;
  localparam int REF_WINDOW_MS = 64;
  localparam int REF_ROWS = 8192;

  // least time in ps to whole cycles, never below one
  function automatic int cyc_up(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RC_CYC = cyc_up(T_RC_PS);
  localparam int RP_CYC = cyc_up(T_RP_PS);
  localparam int XSR_CYC = cyc_up(T_XSR_PS);
  localparam int PDE_CYC = cyc_up(T_PDE_PS);
  // longest interval, rounded down
  localparam int REFI_CYC = REF_WINDOW_MS * CLK_KHZ / REF_ROWS;
  localparam int MAX_LOW_CYC = REF_WINDOW_MS * CLK_KHZ;

  // command pins decode: selected and strobes match
  function automatic logic is_cmd(input logic cs_n, input logic [2:0] s,
                                  input logic [2:0] c);
    return !cs_n && (s == c);
  endfunction
endpackage

// File: rtl/srp_link_if.sv
// command pins between memory controller and sdram command logic
// assumes both ends run on the same clk
`timescale 1ns/100ps
`default_nettype none
interface srp_link_if;
  logic device_select_n;
  logic row_strobe_n;
  logic column_strobe_n;
  logic write_strobe_n;
  logic clock_gate_in;
  logic [12:0] address_lines;
  logic byte_mask;
  logic ext_clk_run;

  modport ctrl (
    output device_select_n, row_strobe_n, column_strobe_n, write_strobe_n,
    output clock_gate_in, address_lines, byte_mask, ext_clk_run
  );
  modport mem (
    input device_select_n, row_strobe_n, column_strobe_n, write_strobe_n,
    input clock_gate_in, address_lines, byte_mask, ext_clk_run
  );
endinterface
`default_nettype wire

// File: rtl/srp_mem_end.sv
// sdram command-state logic: refresh, self refresh, suspend, power down
// assumes the controller is logic on the same clk, so pins need no sync
`timescale 1ns/100ps
`default_nettype none
module srp_mem_end (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  srp_link_if.mem link,
  // core side
  input wire logic bank_busy,
  input wire logic write_cycle,
  input wire logic read_cycle,
  output logic [12:0] refresh_row_ff,
  output logic refresh_pulse_ff,
  output logic int_clk_en_ff,
  output logic buf_en_ff,
  output logic in_self_refresh_ff,
  output logic in_power_down_ff,
  output logic in_suspend_ff,
  output logic write_mask_ff,
  output logic out_en_ff
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {DV_NORMAL, DV_SUSP, DV_PD, DV_SR} srp_dmode_t;

  srp_dmode_t mode_ff, nxt_mode;
  logic cke_prev_ff, nxt_cke_prev;
  logic [srp_pkg::REFI_W-1:0] sr_tmr_ff, nxt_sr_tmr;
  logic [12:0] nxt_refresh_row;
  logic nxt_refresh_pulse, nxt_int_clk_en, nxt_buf_en;
  logic nxt_write_mask, nxt_out_en;
  logic [2:0] strobes;
  logic ref_enc;

  assign strobes = {link.row_strobe_n, link.column_strobe_n,
                    link.write_strobe_n};
  // select low, clock enabled last cycle; address_lines never looked at
  assign ref_enc = srp_pkg::is_cmd(link.device_select_n, strobes,
                                   srp_pkg::CMD_REF) && cke_prev_ff;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_mode = mode_ff;
    nxt_cke_prev = link.clock_gate_in;
    nxt_sr_tmr = sr_tmr_ff;
    nxt_refresh_row = refresh_row_ff;
    // nop and every unlisted pattern start no refresh
    nxt_refresh_pulse = 1'b0;
    nxt_int_clk_en = int_clk_en_ff;
    nxt_buf_en = buf_en_ff;
    nxt_write_mask = write_mask_ff;
    nxt_out_en = out_en_ff;
    case (mode_ff)
      DV_NORMAL: begin
        if (ref_enc && !link.clock_gate_in && !bank_busy) begin
          nxt_mode = DV_SR;
          nxt_sr_tmr = '0;
          nxt_buf_en = 1'b0;
          nxt_int_clk_en = 1'b0;
        end else if (!link.clock_gate_in) begin
          // bank activity picks suspend over power down
          if (bank_busy) begin
            nxt_mode = DV_SUSP;
            nxt_int_clk_en = 1'b0;
          end else begin
            nxt_mode = DV_PD;
            nxt_buf_en = 1'b0;
            nxt_int_clk_en = 1'b0;
          end
        end else begin
          if (ref_enc && !bank_busy) begin
            nxt_refresh_row = refresh_row_ff + 13'h0001;
            nxt_refresh_pulse = 1'b1;
          end
          // byte mask: write mask or read output enable
          if (write_cycle) begin
            nxt_write_mask = link.byte_mask;
          end
          if (read_cycle) begin
            nxt_out_en = !link.byte_mask;
          end
        end
      end
      DV_SUSP: begin
        // operation state frozen; only clock gate watched
        if (link.clock_gate_in) begin
          nxt_mode = DV_NORMAL;
          nxt_int_clk_en = 1'b1;
        end
      end
      DV_PD: begin
        if (link.clock_gate_in) begin
          nxt_mode = DV_NORMAL;
          nxt_int_clk_en = 1'b1;
          nxt_buf_en = 1'b1;
        end
      end
      DV_SR: begin
        // internal timing and addressing, other pins ignored
        if (sr_tmr_ff == srp_pkg::REFI_W'(srp_pkg::REFI_CYC - 1)) begin
          nxt_sr_tmr = '0;
          nxt_refresh_row = refresh_row_ff + 13'h0001;
          nxt_refresh_pulse = 1'b1;
        end else begin
          nxt_sr_tmr = sr_tmr_ff + srp_pkg::REFI_W'(1);
        end
        if (link.clock_gate_in) begin
          nxt_mode = DV_NORMAL;
          nxt_int_clk_en = 1'b1;
          nxt_buf_en = 1'b1;
        end
      end
      default: begin
        nxt_mode = DV_NORMAL;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_ff <= DV_NORMAL;
      cke_prev_ff <= 1'b0;
      sr_tmr_ff <= '0;
      refresh_row_ff <= 13'h0000;
      refresh_pulse_ff <= 1'b0;
      int_clk_en_ff <= 1'b1;
      buf_en_ff <= 1'b1;
      in_self_refresh_ff <= 1'b0;
      in_power_down_ff <= 1'b0;
      in_suspend_ff <= 1'b0;
      write_mask_ff <= 1'b0;
      out_en_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      cke_prev_ff <= nxt_cke_prev;
      sr_tmr_ff <= nxt_sr_tmr;
      refresh_row_ff <= nxt_refresh_row;
      refresh_pulse_ff <= nxt_refresh_pulse;
      int_clk_en_ff <= nxt_int_clk_en;
      buf_en_ff <= nxt_buf_en;
      in_self_refresh_ff <= (nxt_mode == DV_SR);
      in_power_down_ff <= (nxt_mode == DV_PD);
      in_suspend_ff <= (nxt_mode == DV_SUSP);
      write_mask_ff <= nxt_write_mask;
      out_en_ff <= nxt_out_en;
    end
  end
endmodule
`default_nettype wire

// File: rtl/srp_ctrl_end.sv
// memory controller end: refresh scheduling, self refresh and power down
// assumes the sdram end samples the pins on the same clk
`timescale 1ns/100ps
`default_nettype none
module srp_ctrl_end #(
  parameter int MAX_LOW_CYC = srp_pkg::MAX_LOW_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  srp_link_if.ctrl link,
  // user requests, one-cycle pulses
  input wire logic req_refresh,
  input wire logic req_sr_enter,
  input wire logic req_sr_exit,
  input wire logic req_low_enter,
  input wire logic req_low_exit,
  // user levels
  input wire logic burst_mode,
  input wire logic banks_idle,
  input wire logic user_mask,
  // status
  output logic busy_ff,
  output logic done_ff,
  output logic in_self_refresh_ff,
  output logic in_low_ff,
  output logic ref_due_ff
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [3:0] {
    C_IDLE, C_REF, C_RP, C_SR, C_SR_CLK, C_XSR, C_LOW, C_WAKE
  } srp_cst_t;

  localparam int LOW_W = srp_pkg::LOW_W;
  localparam int CNT_W = srp_pkg::CNT_W;
  localparam int BW = srp_pkg::BURST_W;
  localparam int RW = srp_pkg::REFI_W;

  srp_cst_t st_ff, nxt_st;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [LOW_W-1:0] low_ff, nxt_low;
  logic [BW-1:0] burst_ff, nxt_burst;
  logic [RW-1:0] refi_ff, nxt_refi;
  logic sr_pend_ff, nxt_sr_pend;
  logic nxt_ref_due, nxt_busy, nxt_done;
  logic cs_n_ff, nxt_cs_n;
  logic [2:0] cmd_ff, nxt_cmd;
  logic cke_ff, nxt_cke;
  logic clk_run_ff, nxt_clk_run;
  logic mask_ff, nxt_mask;
  logic issue_ref;

  assign link.device_select_n = cs_n_ff;
  assign link.row_strobe_n = cmd_ff[2];
  assign link.column_strobe_n = cmd_ff[1];
  assign link.write_strobe_n = cmd_ff[0];
  assign link.clock_gate_in = cke_ff;
  // address is don't care for every command driven here
  assign link.address_lines = srp_pkg::ADDR_IDLE;
  assign link.byte_mask = mask_ff;
  assign link.ext_clk_run = clk_run_ff;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_low = '0;
    nxt_burst = burst_ff;
    nxt_refi = refi_ff;
    nxt_sr_pend = sr_pend_ff;
    nxt_ref_due = ref_due_ff;
    nxt_done = 1'b0;
    nxt_cs_n = 1'b0;
    nxt_cmd = srp_pkg::CMD_NOP;
    nxt_cke = cke_ff;
    nxt_clk_run = clk_run_ff;
    nxt_mask = user_mask;
    issue_ref = 1'b0;
    case (st_ff)
      C_IDLE: begin
        // refresh first: a late one risks data, others only wait
        if (ref_due_ff && banks_idle && cke_ff) begin
          issue_ref = 1'b1;
        end else if (req_sr_enter && banks_idle && cke_ff) begin
          if (burst_mode) begin
            nxt_burst = BW'(srp_pkg::REF_ROWS);
            nxt_sr_pend = 1'b1;
            nxt_cnt = '0;
            nxt_st = C_RP;
          end else begin
            nxt_cmd = srp_pkg::CMD_REF;
            nxt_cke = 1'b0;
            nxt_st = C_SR;
          end
        end else if (req_low_enter) begin
          // device picks suspend or power down from bank state
          nxt_cke = 1'b0;
          nxt_st = C_LOW;
        end
      end
      C_REF: begin
        // nops only while the row cycle runs
        if (cnt_ff == '0) begin
          nxt_cnt = CNT_W'(srp_pkg::RP_CYC - 1);
          nxt_st = C_RP;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      C_RP: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end else if (burst_ff != '0) begin
          nxt_burst = burst_ff - BW'(1);
          issue_ref = 1'b1;
        end else if (sr_pend_ff) begin
          nxt_sr_pend = 1'b0;
          nxt_cmd = srp_pkg::CMD_REF;
          nxt_cke = 1'b0;
          nxt_st = C_SR;
        end else begin
          nxt_done = 1'b1;
          nxt_st = C_IDLE;
        end
      end
      C_SR: begin
        // clock stopped; gate held low until exit asked
        nxt_cke = 1'b0;
        nxt_clk_run = 1'b0;
        if (req_sr_exit) begin
          nxt_clk_run = 1'b1;
          nxt_st = C_SR_CLK;
        end
      end
      C_SR_CLK: begin
        // clock has run one cycle before the gate rises
        nxt_cke = 1'b1;
        nxt_cnt = CNT_W'(srp_pkg::XSR_CYC - 1);
        nxt_st = C_XSR;
      end
      C_XSR: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end else if (burst_mode) begin
          nxt_burst = BW'(srp_pkg::REF_ROWS);
          nxt_st = C_RP;
        end else begin
          nxt_done = 1'b1;
          nxt_st = C_IDLE;
        end
      end
      C_LOW: begin
        nxt_low = low_ff + LOW_W'(1);
        // forced wake: neither suspend nor power down refreshes
        if (req_low_exit || low_ff == LOW_W'(MAX_LOW_CYC - 2)) begin
          nxt_cke = 1'b1;
          nxt_cnt = CNT_W'(srp_pkg::PDE_CYC);
          nxt_st = C_WAKE;
        end
      end
      C_WAKE: begin
        // nop through setup plus one more cycle
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end else begin
          nxt_done = 1'b1;
          nxt_st = C_IDLE;
        end
      end
      default: begin
        nxt_st = C_IDLE;
      end
    endcase
    if (issue_ref) begin
      nxt_cmd = srp_pkg::CMD_REF;
      nxt_cnt = CNT_W'(srp_pkg::RC_CYC - 1);
      nxt_st = C_REF;
      nxt_ref_due = 1'b0;
    end
    // interval timer pauses in self refresh; set wins over clear
    if (st_ff != C_SR && st_ff != C_SR_CLK) begin
      if (refi_ff == RW'(srp_pkg::REFI_CYC - 1)) begin
        nxt_refi = '0;
        nxt_ref_due = 1'b1;
      end else begin
        nxt_refi = refi_ff + RW'(1);
      end
    end
    if (req_refresh) begin
      nxt_ref_due = 1'b1;
    end
    nxt_busy = (nxt_st != C_IDLE);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= C_IDLE;
      cnt_ff <= '0;
      low_ff <= '0;
      burst_ff <= '0;
      refi_ff <= '0;
      sr_pend_ff <= 1'b0;
      ref_due_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      in_self_refresh_ff <= 1'b0;
      in_low_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      cmd_ff <= srp_pkg::CMD_NOP;
      cke_ff <= 1'b1;
      clk_run_ff <= 1'b1;
      mask_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      low_ff <= nxt_low;
      burst_ff <= nxt_burst;
      refi_ff <= nxt_refi;
      sr_pend_ff <= nxt_sr_pend;
      ref_due_ff <= nxt_ref_due;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      in_self_refresh_ff <= (nxt_st == C_SR);
      in_low_ff <= (nxt_st == C_LOW);
      cs_n_ff <= nxt_cs_n;
      cmd_ff <= nxt_cmd;
      cke_ff <= nxt_cke;
      clk_run_ff <= nxt_clk_run;
      mask_ff <= nxt_mask;
    end
  end
endmodule
`default_nettype wire

// File: sim/srp_link_sva.sv
// checker for the command pins between controller end and sdram end
// assumes one clk for both ends; placed beside the link by the bench
`timescale 1ns/100ps
`default_nettype none
module srp_link_sva #(
  parameter int MAX_LOW_CYC = srp_pkg::MAX_LOW_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link pins
  input wire logic device_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic clock_gate_in,
  input wire logic [12:0] address_lines,
  input wire logic byte_mask,
  input wire logic ext_clk_run
);
  logic [2:0] strb;
  logic nop_c;
  logic ref_c;
  logic sr_c;
  logic [31:0] low_cnt_ff;
  logic [31:0] nxt_low_cnt;

  assign strb = {row_strobe_n, column_strobe_n, write_strobe_n};
  assign nop_c = !device_select_n && (strb == srp_pkg::CMD_NOP);
  assign ref_c = !device_select_n && (strb == srp_pkg::CMD_REF) &&
                 clock_gate_in;
  assign sr_c = !device_select_n && (strb == srp_pkg::CMD_REF) &&
                !clock_gate_in;

  // ****************************************
  // low-time counter
  // ****************************************
  // self refresh excluded: it keeps rows alive by itself
  always_comb begin
    nxt_low_cnt = 32'h0;
    if (!clock_gate_in && ext_clk_run) begin
      nxt_low_cnt = low_cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_cnt_ff <= 32'h0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ref_nops_a: assert property (ref_c |=> nop_c [*2])
    else $error("refresh not followed by two nop cycles");
  ref_gate_a: assert property (ref_c |-> $past(clock_gate_in))
    else $error("refresh issued with gate low one cycle before");
  cmd_set_a: assert property (!device_select_n |->
    (strb == srp_pkg::CMD_NOP || strb == srp_pkg::CMD_REF))
    else $error("unexpected strobe pattern while selected");
  sr_entry_a: assert property (sr_c |=>
    !clock_gate_in && !ext_clk_run)
    else $error("self refresh entry not followed by stopped clock");
  sr_hold_a: assert property (!ext_clk_run |-> !clock_gate_in)
    else $error("gate high while external clock stopped");
  clk_first_a: assert property ($rose(clock_gate_in) |->
    ext_clk_run && $past(ext_clk_run))
    else $error("gate raised before clock restarted");
  exit_nops_a: assert property ($rose(clock_gate_in) |->
    nop_c ##1 nop_c [*2])
    else $error("commands too soon after gate returned high");
  low_limit_a: assert property (low_cnt_ff <= MAX_LOW_CYC)
    else $error("gate held low past the refresh period");

  cover property (ref_c);
  cover property (sr_c);
  cover property ($rose(clock_gate_in));
endmodule
`default_nettype wire

// File: sim/sdram_refresh_power_states_bench.sv
// self-checking bench: controller end facing sdram end, plus a second
// sdram end driven by hand to break controller rules on purpose
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) \
  begin \
    compares++; \
    if ((s) !== (e)) begin \
      errors++; \
      $display("ERROR %s exp %0h got %0h", nm, e, s); \
    end \
  end
module sdram_refresh_power_states_bench;
  localparam int LOW_MAX = 50;
  logic clk, rst_n, burst_mode, banks_idle, user_mask;
  logic req_refresh, req_sr_enter, req_sr_exit, req_low_enter, req_low_exit;
  logic busy, done, c_sr, in_low, m_busy, m_wc, m_rc, m_pulse, m_clk_en;
  logic m_buf_en, m_sr, m_pd, m_sus, m_wm, m_oe, b_busy, b_wc, b_rc;
  logic b_pulse, b_clk_en, b_sus, b_wm, b_oe, ref_due;
  logic [12:0] m_row, b_row;
  int errors = 0, compares = 0, refs = 0, cycles = 0;

  srp_link_if link();
  srp_link_if b_link();
  srp_ctrl_end #(.MAX_LOW_CYC(LOW_MAX)) u_srp_ctrl_end (.clk(clk),
    .rst_n(rst_n), .link(link), .req_refresh(req_refresh),
    .req_sr_enter(req_sr_enter), .req_sr_exit(req_sr_exit),
    .req_low_enter(req_low_enter), .req_low_exit(req_low_exit),
    .burst_mode(burst_mode), .banks_idle(banks_idle),
    .user_mask(user_mask), .busy_ff(busy), .done_ff(done),
    .in_self_refresh_ff(c_sr), .in_low_ff(in_low), .ref_due_ff(ref_due));
  srp_mem_end u_srp_mem_end (.clk(clk), .rst_n(rst_n), .link(link),
    .bank_busy(m_busy), .write_cycle(m_wc), .read_cycle(m_rc),
    .refresh_row_ff(m_row), .refresh_pulse_ff(m_pulse),
    .int_clk_en_ff(m_clk_en), .buf_en_ff(m_buf_en),
    .in_self_refresh_ff(m_sr), .in_power_down_ff(m_pd),
    .in_suspend_ff(m_sus), .write_mask_ff(m_wm), .out_en_ff(m_oe));
  srp_mem_end u_srp_mem_end_b (.clk(clk), .rst_n(rst_n), .link(b_link),
    .bank_busy(b_busy), .write_cycle(b_wc), .read_cycle(b_rc),
    .refresh_row_ff(b_row), .refresh_pulse_ff(b_pulse),
    .int_clk_en_ff(b_clk_en), .buf_en_ff(), .in_self_refresh_ff(),
    .in_power_down_ff(), .in_suspend_ff(b_sus), .write_mask_ff(b_wm),
    .out_en_ff(b_oe));
  srp_link_sva #(.MAX_LOW_CYC(LOW_MAX)) u_srp_link_sva (.clk(clk),
    .rst_n(rst_n), .device_select_n(link.device_select_n),
    .row_strobe_n(link.row_strobe_n),
    .column_strobe_n(link.column_strobe_n),
    .write_strobe_n(link.write_strobe_n),
    .clock_gate_in(link.clock_gate_in),
    .address_lines(link.address_lines), .byte_mask(link.byte_mask),
    .ext_clk_run(link.ext_clk_run));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************
  // run control
  // ****************************************
  // the two bursts take about 50k cycles; ceiling keeps a hang short
  always @(posedge clk) begin
    cycles++;
    if (m_pulse === 1'b1) begin
      refs++;
    end
    if (cycles == 70000) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // request selects: which pulse is held and which state answers it
  localparam int H_LOW_IN = 0;
  localparam int H_LOW_OUT = 1;
  localparam int H_SR_IN = 2;
  localparam int H_SR_OUT = 3;

  task automatic set_req(input int sel, input logic v);
    case (sel)
      H_LOW_IN: req_low_enter = v;
      H_LOW_OUT: req_low_exit = v;
      H_SR_IN: req_sr_enter = v;
      default: req_sr_exit = v;
    endcase
  endtask

  function automatic logic hold_state(input int sel);
    case (sel)
      H_LOW_IN, H_LOW_OUT: return in_low;
      H_SR_IN: return m_sr;
      default: return c_sr;
    endcase
  endfunction

  // held until the state shows: a pulse may land during a refresh
  task automatic hold_req(input int sel, input logic v);
    int n;
    set_req(sel, 1'b1);
    for (n = 0; n < 40000 && hold_state(sel) !== v; n++) step();
    set_req(sel, 1'b0);
    for (n = 0; n < 40000 && (hold_state(sel) !== v || busy !== 1'b0) &&
         v == 1'b0; n++) step();
    if (v == 1'b0) begin
      `CHK("done_pulse", 1'b1, done)
    end
    step();
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_link_b();
    b_link.device_select_n = 1'b1;
    {b_link.row_strobe_n, b_link.column_strobe_n, b_link.write_strobe_n}
      = srp_pkg::CMD_REF;
    repeat (3) step();
    `CHK("deselect_pulse", 1'b0, b_pulse)
    b_link.device_select_n = 1'b0;
    step();
    b_link.device_select_n = 1'b1;
    `CHK("ref_pulse", 1'b1, b_pulse)
    `CHK("ref_row", 13'h1, b_row)
    b_busy = 1'b1;
    b_link.device_select_n = 1'b0;
    step();
    b_link.device_select_n = 1'b1;
    `CHK("busy_ref", 1'b0, b_pulse)
    {b_link.row_strobe_n, b_link.column_strobe_n, b_link.write_strobe_n}
      = srp_pkg::CMD_NOP;
    b_link.byte_mask = 1'b1;
    b_wc = 1'b1;
    repeat (2) step();
    `CHK("write_mask", 1'b1, b_wm)
    b_wc = 1'b0;
    b_rc = 1'b1;
    b_link.byte_mask = 1'b0;
    repeat (2) step();
    `CHK("read_out_on", 1'b1, b_oe)
    b_link.byte_mask = 1'b1;
    repeat (2) step();
    `CHK("read_out_off", 1'b0, b_oe)
    b_link.clock_gate_in = 1'b0;
    repeat (3) step();
    `CHK("suspend", 1'b1, b_sus)
    `CHK("suspend_clk", 1'b0, b_clk_en)
    b_link.clock_gate_in = 1'b1;
    repeat (3) step();
    `CHK("resume_clk", 1'b1, b_clk_en)
  endtask

  task automatic t_refresh();
    int n;
    logic [12:0] r0;
    banks_idle = 1'b0;
    n = refs;
    req_refresh = 1'b1;
    step();
    req_refresh = 1'b0;
    repeat (20) step();
    `CHK("ref_busy_banks", n, refs)
    `CHK("ref_owed", 1'b1, ref_due)
    banks_idle = 1'b1;
    for (n = 0; n < 20 && m_pulse !== 1'b1; n++) step();
    r0 = m_row;
    req_refresh = 1'b1;
    step();
    req_refresh = 1'b0;
    for (n = 0; n < 20 && m_pulse !== 1'b1; n++) step();
    `CHK("ref_row_step", r0 + 13'h1, m_row)
    user_mask = 1'b1;
    m_wc = 1'b1;
    repeat (3) step();
    `CHK("mask_path", 1'b1, m_wm)
    n = refs;
    repeat (srp_pkg::REFI_CYC * 8) step();
    `CHK("ref_rate", 1'b1, (refs - n) >= 7 && (refs - n) <= 9)
  endtask

  task automatic t_low(input logic bb);
    int n;
    m_busy = bb;
    hold_req(H_LOW_IN, 1'b1);
    for (n = 0; n < 8 && (m_pd | m_sus) !== 1'b1; n++) step();
    `CHK("pd_mode", !bb, m_pd)
    `CHK("buf_state", bb, m_buf_en)
    `CHK("clk_masked", 1'b0, m_clk_en)
    if (bb) begin
      for (n = 0; n < 200 && link.clock_gate_in !== 1'b1; n++) step();
      `CHK("low_bound", 1'b1, n <= LOW_MAX)
      for (n = 0; n < 20 && busy !== 1'b0; n++) step();
    end else begin
      hold_req(H_LOW_OUT, 1'b0);
    end
    `CHK("buf_back", 1'b1, m_buf_en)
    `CHK("clk_back", 1'b1, m_clk_en)
    m_busy = 1'b0;
  endtask

  task automatic t_self(input logic bm);
    int n;
    logic [12:0] r0;
    burst_mode = bm;
    n = refs;
    hold_req(H_SR_IN, 1'b1);
    if (bm) begin
      `CHK("burst_in", 1'b1, (refs - n) >= 8192)
    end
    `CHK("clk_stopped", 1'b0, link.ext_clk_run)
    r0 = m_row;
    repeat (srp_pkg::REFI_CYC * 2 + 4) step();
    `CHK("sr_rows_move", 1'b1, m_row !== r0)
    n = refs;
    hold_req(H_SR_OUT, 1'b0);
    `CHK("sr_left", 1'b0, m_sr)
    if (bm) begin
      `CHK("burst_out", 1'b1, (refs - n) >= 8192)
    end
  endtask

  initial begin
    {rst_n, burst_mode, user_mask, req_refresh, req_sr_enter} = 5'h0;
    {req_sr_exit, req_low_enter, req_low_exit, m_busy, m_wc} = 5'h0;
    {m_rc, b_busy, b_wc, b_rc, b_link.byte_mask} = 5'h0;
    banks_idle = 1'b1;
    {b_link.device_select_n, b_link.clock_gate_in} = 2'h3;
    {b_link.row_strobe_n, b_link.column_strobe_n, b_link.write_strobe_n}
      = srp_pkg::CMD_NOP;
    b_link.address_lines = 13'h0000;
    b_link.ext_clk_run = 1'b1;
    repeat (20) step();
    rst_n = 1'b1;
    step();
    t_link_b();
    t_refresh();
    t_low(1'b0);
    t_low(1'b1);
    t_self(1'b0);
    t_self(1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
